// *** pkg/dpm_pkg.sv ***
// Constants, field layout, timing counts and state type for the mailbox port master.
// Assumes one 25 MHz clock and a single asynchronous dual-port memory port on the pins.
package dpm_pkg;

    // Register offsets on the APB side
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_ADDR   = 8'h04;
    localparam logic [7:0] ADDR_WDATA  = 8'h08;
    localparam logic [7:0] ADDR_RDATA  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Control register fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_HI_BIT = 3;
    localparam int CTRL_LO_BIT = 4;

    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_MBOX_BIT = 2;
    localparam int STAT_CSEEN_BIT = 3;
    localparam int STAT_CNOW_BIT = 4;

    // Operation codes: bit 1 selects token latch, bit 0 selects write
    localparam logic [1:0] OP_MEM_RD = 2'h0;
    localparam logic [1:0] OP_MEM_WR = 2'h1;
    localparam logic [1:0] OP_TOK_RD = 2'h2;
    localparam logic [1:0] OP_TOK_WR = 2'h3;

    // Reset values
    localparam logic [15:0] RST_DATA = 16'h0000;
    localparam logic [1:0]  RST_LANES = 2'h3;

    // Timing in ns and derived cycle counts
    localparam int CLK_MHZ      = 25;
    localparam int T_ACCESS_NS  = 25;
    localparam int T_WRITE_NS   = 20;
    localparam int T_FLOW_NS    = 25;
    localparam int T_SETTLE_NS  = 20;
    localparam int CNT_W        = 8;

    // Least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c < 1) begin
            c = 1;
        end
        return c;
    endfunction : ns_to_cyc

    localparam logic [7:0] C_SETTLE = 8'(ns_to_cyc(T_SETTLE_NS));
    localparam logic [7:0] C_WRITE  = 8'(ns_to_cyc(T_WRITE_NS));
    localparam logic [7:0] C_READ   = 8'((ns_to_cyc(T_ACCESS_NS) > ns_to_cyc(T_FLOW_NS)) ?
                                         ns_to_cyc(T_ACCESS_NS) : ns_to_cyc(T_FLOW_NS));

    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_SETUP  = 5'b00010,
        S_STROBE = 5'b00100,
        S_END    = 5'b01000,
        S_RECOV  = 5'b10000
    } dpm_state_t;

endpackage : dpm_pkg

// *** verilog/dpm_wait.sv ***
// Down counter that paces the pin sequence.
// Assumes the caller loads it on the same edge that enters a timed state.
`timescale 1ns/1ns
module dpm_wait #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_done
);
    logic [W-1:0] cnt_r;

    // Load wins over counting so back-to-back timed states restart cleanly
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign o_done = (cnt_r == '0);
endmodule : dpm_wait

// *** verilog/dpm_ctrl.sv ***
// APB-programmed master for one port of an asynchronous dual-port memory.
// Assumes the memory pins are sampled and driven on i_clk; the far port is another master.
`timescale 1ns/1ns
module dpm_ctrl #(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic      [ADDR_W-1:0] o_addr,
    output logic                   o_sel_n,
    output logic                   o_wr_n,
    output logic                   o_oe_n,
    output logic                   o_hi_lane_n,
    output logic                   o_lo_lane_n,
    output logic                   o_tok_sel_n,
    output logic      [15:0]       o_data,
    output logic                   o_data_oe,
    input  wire logic [15:0]       i_data,
    input  wire logic              i_mbox_flag_n,
    input  wire logic              i_contention_n
);
    dpm_pkg::dpm_state_t state_r, state_nxt;
    logic [1:0]        op_r, op_nxt;
    logic [1:0]        lanes_r, lanes_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt, pin_addr_r, pin_addr_nxt;
    logic [15:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic              sel_n_r, sel_n_nxt, wr_n_r, wr_n_nxt, oe_n_r, oe_n_nxt;
    logic              hi_n_r, hi_n_nxt, lo_n_r, lo_n_nxt, tok_n_r, tok_n_nxt;
    logic              data_oe_r, data_oe_nxt;
    logic              done_r, done_nxt, cseen_r, cseen_nxt;
    logic              pready_r;
    logic [31:0]       prdata_r, prdata_nxt;
    logic              load;
    logic [7:0]        cnt_val;
    logic              wait_done;

    localparam int C_READ_I = int'(dpm_pkg::C_READ);

    // APB decode: one wait state, write acts at the edge that sees pready
    wire apb_acc   = i_psel & i_penable & ~pready_r;
    wire apb_fire  = i_psel & i_penable & pready_r;
    wire wr_fire   = apb_fire & i_pwrite;
    wire hit_ctrl  = (i_paddr == dpm_pkg::ADDR_CTRL);
    wire hit_addr  = (i_paddr == dpm_pkg::ADDR_ADDR);
    wire hit_wdata = (i_paddr == dpm_pkg::ADDR_WDATA);
    wire hit_rdata = (i_paddr == dpm_pkg::ADDR_RDATA);
    wire hit_stat  = (i_paddr == dpm_pkg::ADDR_STATUS);
    wire idle      = (state_r == dpm_pkg::S_IDLE);
    wire go_req    = wr_fire & hit_ctrl & i_pwdata[dpm_pkg::CTRL_GO_BIT] & idle;
    wire [1:0] new_op    = i_pwdata[dpm_pkg::CTRL_OP_LSB +: 2];
    wire [1:0] raw_lanes = {i_pwdata[dpm_pkg::CTRL_HI_BIT], i_pwdata[dpm_pkg::CTRL_LO_BIT]};
    // No lane chosen would power the port down, so take it as both lanes
    wire [1:0] new_lanes = (raw_lanes == 2'h0) ? 2'h3 : raw_lanes;
    wire new_tok   = new_op[1];
    wire is_tok    = op_r[1];
    wire is_wr     = op_r[0];
    wire clr_done  = wr_fire & hit_stat & i_pwdata[dpm_pkg::STAT_DONE_BIT];
    wire clr_cseen = wr_fire & hit_stat & i_pwdata[dpm_pkg::STAT_CSEEN_BIT];
    // Contention only matters for array cycles; flag taken straight from the pin, no glue
    wire contended = ~is_tok & ~i_contention_n;
    // Lanes not selected float on the far side, so keep them out of the result
    wire [15:0] lane_mask = {{8{lanes_r[1]}}, {8{lanes_r[0]}}};
    wire [15:0] rd_value  = is_tok ? {16{i_data[0]}} : (i_data & lane_mask);
    wire [31:0] status_w  = {27'h0, ~i_contention_n, cseen_r, ~i_mbox_flag_n, done_r, ~idle};

    dpm_wait #(.W(dpm_pkg::CNT_W)) u_wait (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_load  (load),
        .i_count (cnt_val),
        .o_done  (wait_done)
    );

    // Register read mux; unmapped offsets read as zero
    always_comb begin
        if (hit_ctrl) begin
            prdata_nxt = {27'h0, lanes_r[0], lanes_r[1], op_r, 1'b0};
        end else if (hit_addr) begin
            prdata_nxt = 32'(addr_r);
        end else if (hit_wdata) begin
            prdata_nxt = {16'h0, wdata_r};
        end else if (hit_rdata) begin
            prdata_nxt = {16'h0, rdata_r};
        end else if (hit_stat) begin
            prdata_nxt = status_w;
        end else begin
            prdata_nxt = 32'h0;
        end
    end

    // Software-written registers; address and data are frozen while a cycle runs
    always_comb begin
        addr_nxt  = (wr_fire & hit_addr & idle) ? i_pwdata[ADDR_W-1:0] : addr_r;
        wdata_nxt = (wr_fire & hit_wdata & idle) ? i_pwdata[15:0] : wdata_r;
        op_nxt    = go_req ? new_op : op_r;
        lanes_nxt = go_req ? new_lanes : lanes_r;
        // Hardware set wins over a same-cycle software clear
        done_nxt  = (state_r == dpm_pkg::S_RECOV) | (done_r & ~clr_done);
        cseen_nxt = ((state_r == dpm_pkg::S_SETUP) & contended) | (cseen_r & ~clr_cseen);
    end

    // Pin sequencer
    always_comb begin
        state_nxt    = state_r;
        load         = 1'b0;
        cnt_val      = 8'h00;
        pin_addr_nxt = pin_addr_r;
        sel_n_nxt    = sel_n_r;
        wr_n_nxt     = wr_n_r;
        oe_n_nxt     = oe_n_r;
        hi_n_nxt     = hi_n_r;
        lo_n_nxt     = lo_n_r;
        tok_n_nxt    = tok_n_r;
        data_oe_nxt  = data_oe_r;
        rdata_nxt    = rdata_r;
        case (state_r)
            dpm_pkg::S_IDLE: begin
                if (go_req) begin
                    state_nxt = dpm_pkg::S_SETUP;
                    load      = 1'b1;
                    cnt_val   = dpm_pkg::C_SETTLE;
                    // Token cycles keep select high and use only the latch index
                    sel_n_nxt = new_tok;
                    tok_n_nxt = ~new_tok;
                    pin_addr_nxt = new_tok ? ADDR_W'(addr_r[2:0]) : addr_r;
                    hi_n_nxt  = new_tok | ~new_lanes[1];
                    lo_n_nxt  = new_tok | ~new_lanes[0];
                end
            end
            dpm_pkg::S_SETUP: begin
                // Hold off the strobe until contention has settled and is clear
                if (wait_done & ~contended) begin
                    state_nxt   = dpm_pkg::S_STROBE;
                    load        = 1'b1;
                    cnt_val     = is_wr ? dpm_pkg::C_WRITE : dpm_pkg::C_READ;
                    wr_n_nxt    = ~is_wr;
                    oe_n_nxt    = is_wr;
                    data_oe_nxt = is_wr;
                end
            end
            dpm_pkg::S_STROBE: begin
                if (wait_done) begin
                    state_nxt = dpm_pkg::S_END;
                    // Rising strobe commits the write with data still driven
                    wr_n_nxt  = 1'b1;
                    oe_n_nxt  = 1'b1;
                    rdata_nxt = is_wr ? rdata_r : rd_value;
                end
            end
            dpm_pkg::S_END: begin
                state_nxt   = dpm_pkg::S_RECOV;
                sel_n_nxt   = 1'b1;
                tok_n_nxt   = 1'b1;
                hi_n_nxt    = 1'b1;
                lo_n_nxt    = 1'b1;
                data_oe_nxt = 1'b0;
            end
            dpm_pkg::S_RECOV: begin
                state_nxt = dpm_pkg::S_IDLE;
            end
            default: begin
                state_nxt = dpm_pkg::S_IDLE;
            end
        endcase
    end

    // Bus side flops
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= apb_acc;
            prdata_r <= apb_acc ? prdata_nxt : prdata_r;
        end
    end

    // Control and status flops
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= dpm_pkg::S_IDLE;
            op_r    <= dpm_pkg::OP_MEM_RD;
            lanes_r <= dpm_pkg::RST_LANES;
            addr_r  <= '0;
            wdata_r <= dpm_pkg::RST_DATA;
            rdata_r <= dpm_pkg::RST_DATA;
            done_r  <= 1'b0;
            cseen_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            lanes_r <= lanes_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            done_r  <= done_nxt;
            cseen_r <= cseen_nxt;
        end
    end

    // Pin flops; everything idles deselected and undriven
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_addr_r <= '0;
            sel_n_r    <= 1'b1;
            wr_n_r     <= 1'b1;
            oe_n_r     <= 1'b1;
            hi_n_r     <= 1'b1;
            lo_n_r     <= 1'b1;
            tok_n_r    <= 1'b1;
            data_oe_r  <= 1'b0;
        end else begin
            pin_addr_r <= pin_addr_nxt;
            sel_n_r    <= sel_n_nxt;
            wr_n_r     <= wr_n_nxt;
            oe_n_r     <= oe_n_nxt;
            hi_n_r     <= hi_n_nxt;
            lo_n_r     <= lo_n_nxt;
            tok_n_r    <= tok_n_nxt;
            data_oe_r  <= data_oe_nxt;
        end
    end

    assign o_prdata    = prdata_r;
    assign o_pready    = pready_r;
    assign o_pslverr   = 1'b0;
    assign o_addr      = pin_addr_r;
    assign o_sel_n     = sel_n_r;
    assign o_wr_n      = wr_n_r;
    assign o_oe_n      = oe_n_r;
    assign o_hi_lane_n = hi_n_r;
    assign o_lo_lane_n = lo_n_r;
    assign o_tok_sel_n = tok_n_r;
    assign o_data      = wdata_r;
    assign o_data_oe   = data_oe_r;

    // Checks on the driven pins and on the done flag
    a_no_forbid_combo: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(!sel_n_r && !tok_n_r))
        else $error("select and token select low together");
    a_oe_no_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !oe_n_r |-> (!data_oe_r && (!sel_n_r || !tok_n_r)))
        else $error("read strobe without select or with data driven");
    a_write_commit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(wr_n_r) |-> (data_oe_r && $past(data_oe_r) && !(sel_n_r && tok_n_r)))
        else $error("write strobe rose without data or select held");
    a_tok_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !tok_n_r |-> (sel_n_r && (pin_addr_r >> 3) == '0))
        else $error("token cycle with select low or high address bits");
    a_write_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($fell(wr_n_r) && !sel_n_r) |-> $past(i_contention_n))
        else $error("write started during contention");
    a_flow_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(oe_n_r) |-> $past(!oe_n_r, C_READ_I))
        else $error("read strobe shorter than flow-through wait");
    a_lane_chosen: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !sel_n_r |-> !(hi_n_r && lo_n_r))
        else $error("array cycle with no lane selected");
    a_done_after: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_r == dpm_pkg::S_RECOV) |=> (done_r && state_r == dpm_pkg::S_IDLE))
        else $error("done not set after cycle");
    a_setup_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_r == dpm_pkg::S_STROBE && $past(state_r == dpm_pkg::S_SETUP))
        |-> $past(!(sel_n_r && tok_n_r), 2))
        else $error("strobe without select settle cycle");
endmodule : dpm_ctrl

// *** tb/dpm_dev_model.sv ***
// Behavioural model of one dual-port memory device, seen from its left port.
// Assumes the controller's pins change just after i_clk; the right port is
// worked by the bench through the far inputs, one access per clock.
`timescale 1ns/1ns
module dpm_dev_model #(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_clk,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_sel_n,
    input  wire logic              i_wr_n,
    input  wire logic              i_oe_n,
    input  wire logic              i_hi_n,
    input  wire logic              i_lo_n,
    input  wire logic              i_tok_n,
    input  wire logic [15:0]       i_bus,
    input  wire logic              i_far_sel,
    input  wire logic              i_far_we,
    input  wire logic [ADDR_W-1:0] i_far_addr,
    input  wire logic [15:0]       i_far_wdata,
    output logic      [15:0]       o_q,
    output logic                   o_mbox_n,
    output logic                   o_rflag_n,
    output logic                   o_cont_n
);
    localparam logic [ADDR_W-1:0] TOP = '1;
    logic [15:0]       mem_r [0:(1<<ADDR_W)-1];
    logic [7:0]        tok_r;
    logic [15:0]       pat_r;
    logic              ps_r, pw_r, ph_r, pl_r, pt_r;
    logic [ADDR_W-1:0] pa_r;
    logic [15:0]       pd_r;

    // Access decoding; both lane selects high means powered down
    wire mem_en = !i_sel_n && i_tok_n && !(i_hi_n && i_lo_n);
    wire tok_en = !i_tok_n && (i_sel_n || (i_hi_n && i_lo_n));
    wire rd_mem = mem_en && i_wr_n && !i_oe_n;
    wire rd_tok = tok_en && i_wr_n && !i_oe_n;
    wire act_p  = !ps_r || !pt_r;
    wire act_n  = !i_sel_n || !i_tok_n;
    wire commit = !pw_r && act_p && (i_wr_n || !act_n);
    // Far port always arrives first here, so the left port is flagged; no delay
    assign o_cont_n = !(i_far_sel && mem_en && i_far_addr == i_addr);

    // Read drive; lanes nobody drives show a pattern that moves every cycle
    always_comb begin
        o_q = pat_r;
        if (rd_tok) begin
            o_q = {16{tok_r[i_addr[2:0]]}};
        end else if (rd_mem) begin
            if (!i_hi_n) o_q[15:8] = mem_r[i_addr][15:8];
            if (!i_lo_n) o_q[7:0] = mem_r[i_addr][7:0];
        end
    end

    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) mem_r[i] = 16'h0000;
        tok_r = 8'hff;
        pat_r = 16'ha5c3;
        {ps_r, pw_r, ph_r, pl_r, pt_r} = 5'h1f;
        o_mbox_n = 1'b1;
        o_rflag_n = 1'b1;
    end

    // Writes land on the edge that ends the strobe, using values held while low
    always @(posedge i_clk) begin
        {ps_r, pw_r, ph_r, pl_r, pt_r} <= {i_sel_n, i_wr_n, i_hi_n, i_lo_n, i_tok_n};
        pa_r <= i_addr;
        pd_r <= i_bus;
        pat_r <= pat_r + 16'h1357;
        if (commit && !pt_r) begin
            tok_r[pa_r[2:0]] <= pd_r[0];
        end else if (commit && o_cont_n) begin
            if (!ph_r) mem_r[pa_r][15:8] <= pd_r[15:8];
            if (!pl_r) mem_r[pa_r][7:0] <= pd_r[7:0];
            if (pa_r == TOP) o_rflag_n <= 1'b0;
        end
        if (rd_mem && i_addr == TOP - 1 && o_cont_n) o_mbox_n <= 1'b1;
        if (i_far_sel && i_far_we) begin
            mem_r[i_far_addr] <= i_far_wdata;
            if (i_far_addr == TOP - 1) o_mbox_n <= 1'b0;
        end
        if (i_far_sel && !i_far_we && i_far_addr == TOP) o_rflag_n <= 1'b1;
    end
endmodule : dpm_dev_model

// *** tb/dpm_ctrl_test.sv ***
// Self-checking bench for the APB port master driving one device port.
// Assumes the device model of this folder and a reference memory kept here.
`timescale 1ns/1ns
module dpm_ctrl_test;
    localparam int AW = 12;
    localparam logic [AW-1:0] TOP = '1;
    logic          i_clk = 1'b0, i_rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, rd, st;
    logic          pready, sel_n, wr_n, oe_n, hi_n, lo_n, tok_n, data_oe, mbox_n, rflag_n, cont_n;
    logic [AW-1:0] addr, a, far_addr = '0;
    logic [15:0]   dout, dq, bus, wd, far_wd = 16'h0, ref_mem [int];
    logic          far_sel = 1'b0, far_we = 1'b0, h, l;
    integer        seed = 32'hf0500ec2;
    int            miscompares = 0, cmp_count = 0, cyc = 0;

    // Wire resolution: the controller wins only while it drives
    assign bus = data_oe ? dout : dq;
    always #20 i_clk = ~i_clk;

    dpm_ctrl #(.ADDR_W(AW)) u_dpm_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(), .o_addr(addr), .o_sel_n(sel_n), .o_wr_n(wr_n),
        .o_oe_n(oe_n), .o_hi_lane_n(hi_n), .o_lo_lane_n(lo_n), .o_tok_sel_n(tok_n),
        .o_data(dout), .o_data_oe(data_oe), .i_data(bus), .i_mbox_flag_n(mbox_n),
        .i_contention_n(cont_n));
    dpm_dev_model #(.ADDR_W(AW)) u_dpm_dev_model (.i_clk(i_clk), .i_addr(addr), .i_sel_n(sel_n),
        .i_wr_n(wr_n), .i_oe_n(oe_n), .i_hi_n(hi_n), .i_lo_n(lo_n), .i_tok_n(tok_n),
        .i_bus(bus), .i_far_sel(far_sel), .i_far_we(far_we), .i_far_addr(far_addr),
        .i_far_wdata(far_wd), .o_q(dq), .o_mbox_n(mbox_n), .o_rflag_n(rflag_n),
        .o_cont_n(cont_n));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Hang guard, well above the fewer than two thousand cycles the sequence needs
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask : chk

    // One APB transfer; pready is sampled at the rising edge, the answer taken there
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic start_op(input logic [1:0] op, input logic hi, lo);
        apb(1'b1, dpm_pkg::ADDR_ADDR, 32'(a));
        apb(1'b1, dpm_pkg::ADDR_WDATA, {16'h0, wd});
        apb(1'b1, dpm_pkg::ADDR_CTRL, (32'(op) << dpm_pkg::CTRL_OP_LSB) | 32'h1 |
            (32'(hi) << dpm_pkg::CTRL_HI_BIT) | (32'(lo) << dpm_pkg::CTRL_LO_BIT));
    endtask : start_op

    // Poll for done, keep the status seen, clear it, fetch the read result
    task automatic finish_op();
        do begin
            apb(1'b0, dpm_pkg::ADDR_STATUS, 32'h0);
        end while (rd[dpm_pkg::STAT_DONE_BIT] !== 1'b1);
        st = rd;
        apb(1'b1, dpm_pkg::ADDR_STATUS, 32'h0000000a);
        apb(1'b0, dpm_pkg::ADDR_RDATA, 32'h0);
    endtask : finish_op

    task automatic op(input logic [1:0] o, input logic hi, lo);
        start_op(o, hi, lo);
        finish_op();
    endtask : op

    task automatic far(input logic w, input logic [AW-1:0] fa, input logic [15:0] fd);
        @(posedge i_clk);
        far_sel <= 1'b1;
        far_we <= w;
        far_addr <= fa;
        far_wd <= fd;
        @(posedge i_clk);
        far_sel <= 1'b0;
    endtask : far

    function automatic logic [15:0] lmask(input logic hi, lo);
        return (!hi && !lo) ? 16'hffff : {{8{hi}}, {8{lo}}};
    endfunction : lmask

    function automatic logic [15:0] rget(input logic [AW-1:0] k);
        return ref_mem.exists(int'(k)) ? ref_mem[int'(k)] : 16'h0000;
    endfunction : rget

    // Main sequence: reset, registers, memory lanes, tokens, mailboxes, contention
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        chk("idle pins", 32'h3f, {sel_n, wr_n, oe_n, hi_n, lo_n, tok_n});
        apb(1'b0, dpm_pkg::ADDR_STATUS, 32'h0);
        chk("status reset", 32'h0, rd);
        apb(1'b1, dpm_pkg::ADDR_RDATA, 32'hffff);
        apb(1'b0, dpm_pkg::ADDR_RDATA, 32'h0);
        chk("rdata read only", 32'h0, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Few addresses, so partial-lane writes pile onto one another
        for (int i = 0; i < 12; i++) begin
            a = AW'($random(seed) & 7);
            wd = 16'($random(seed));
            {h, l} = 2'($random(seed));
            op(dpm_pkg::OP_MEM_WR, h, l);
            ref_mem[int'(a)] = (rget(a) & ~lmask(h, l)) | (wd & lmask(h, l));
            {h, l} = 2'($random(seed));
            op(dpm_pkg::OP_MEM_RD, h, l);
            chk("mem rdata", {16'h0, rget(a) & lmask(h, l)}, rd);
        end
        // Every latch, with high address bits that must be ignored
        for (int i = 0; i < 8; i++) begin
            a = AW'({$random(seed)} << 3) | AW'(i);
            wd = 16'($random(seed)) & 16'hfffe;
            op(dpm_pkg::OP_TOK_WR, 1'b0, 1'b0);
            op(dpm_pkg::OP_TOK_RD, 1'b0, 1'b0);
            chk("token taken", 32'h0, rd);
            wd = 16'($random(seed)) | 16'h0001;
            op(dpm_pkg::OP_TOK_WR, 1'b0, 1'b0);
            op(dpm_pkg::OP_TOK_RD, 1'b0, 1'b0);
            chk("token freed", 32'hffff, rd);
        end
        far(1'b1, TOP - 1, 16'h1234);
        apb(1'b0, dpm_pkg::ADDR_STATUS, 32'h0);
        chk("own flag set", 32'h1, 32'(rd[dpm_pkg::STAT_MBOX_BIT]));
        a = TOP;
        wd = 16'hbeef;
        op(dpm_pkg::OP_MEM_WR, 1'b0, 1'b0);
        chk("far flag set", 32'h0, 32'(rflag_n));
        op(dpm_pkg::OP_MEM_RD, 1'b0, 1'b0);
        chk("far mailbox", 32'hbeef, rd);
        chk("far flag kept", 32'h0, 32'(rflag_n));
        a = TOP - 1;
        op(dpm_pkg::OP_MEM_RD, 1'b0, 1'b0);
        chk("own mailbox", 32'h1234, rd);
        apb(1'b0, dpm_pkg::ADDR_STATUS, 32'h0);
        chk("own flag clear", 32'h0, 32'(rd[dpm_pkg::STAT_MBOX_BIT]));
        // Far port holds the word first; the write must wait for it
        a = 12'h005;
        wd = 16'hc3c3;
        far_addr <= a;
        far_we <= 1'b0;
        far_sel <= 1'b1;
        start_op(dpm_pkg::OP_MEM_WR, 1'b1, 1'b1);
        repeat (10) @(posedge i_clk);
        apb(1'b0, dpm_pkg::ADDR_STATUS, 32'h0);
        chk("busy contended", 32'h11, rd & 32'h11);
        chk("strobe held", 32'h1, 32'(wr_n));
        // Address written while busy must be ignored, so the late write still lands at 5
        apb(1'b1, dpm_pkg::ADDR_ADDR, 32'h7);
        far_sel <= 1'b0;
        finish_op();
        chk("contention seen", 32'h1, 32'(st[dpm_pkg::STAT_CSEEN_BIT]));
        op(dpm_pkg::OP_MEM_RD, 1'b1, 1'b1);
        chk("late write", 32'hc3c3, rd);
        end_of_test();
    end
endmodule : dpm_ctrl_test
